// File: src/rcp_ctrl.sv
// reference clock input selection, pll setup and lock fallback control
`timescale 1ns/100ps
`include "rcp_map.svh"

// Function
// - bits 7:5 pick differential, crystal or cmos input, pll on or off; default differential off.
// - bit 7 set selects cmos mode, reference taken from one pin only.
// - bit 1 low holds pll digital logic in reset.
// - bit 5 clear powers the pll up, set powers it down.
// - bit 4 selects the low-range loop filter for slow references while bit 5 is clear.
// - bit 3 divides the reference by two ahead of the phase detector.
// - bit 2 picks one of two vcos; pll operation otherwise unchanged.
// - bit 15 enables divide-by-two at pll output, halving the factor.
// - feedback divider is divide-by-n from bits 13:9 then divide-by-1/2 from bit 14.
// - bits 15:9 and bit 3 together set the multiplication factor.
// - factor is n, doubled by bit 14, halved by bit 15 and bit 3; n zero means 32.
// - programmable factor spans one quarter to sixty-four times the reference.
// - bit 0 is read-only and shows the pll lock indication.
// - while pll selected but unlocked, sample clock runs from the reference.
// - when lock rises, sample clock switches to pll output after the two-stage lock synchroniser.
// - when lock falls, sample clock returns to reference while pll reacquires.
module rcp_ctrl
  import rcp_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic                      ce,
  input  wire logic                      cfg_wr_en,
  input  wire logic [`RCP_CFG_WIDTH-1:0] cfg_wr_data,
  input  wire logic                      pll_lock_raw,
  output      logic [`RCP_CFG_WIDTH-1:0] cfg_rd_data_q,
  output      rcp_ctrl_s                 ctrl_q
);

  logic [`RCP_CFG_WIDTH-1:0] cfg_q;
  logic                      lock_meta_q;
  logic                      lock_sync_q;
  rcp_ctrl_s                 ctrl_d;

  // factor in quarter steps, so 0.25x..64x fits 1..256
  function automatic logic [8:0] rcp_mult_x4(input logic [`RCP_CFG_WIDTH-1:0] cfg);
    logic [8:0] m;
    m = (cfg[`RCP_FB_N_HI:`RCP_FB_N_LO] == 5'h00) ? {1'b0, `RCP_N_ZERO_VALUE, 2'b00}
                                                  : {2'b00, cfg[`RCP_FB_N_HI:`RCP_FB_N_LO], 2'b00};
    if (cfg[`RCP_BIT_FB_DIV2]) begin
      m = {m[7:0], 1'b0};
    end
    if (cfg[`RCP_BIT_OUT_DIV2]) begin
      m = {1'b0, m[8:1]};
    end
    if (cfg[`RCP_BIT_REF_DIV2]) begin
      m = {1'b0, m[8:1]};
    end
    return m;
  endfunction

  // configuration word; bit 0 is never stored, it is the lock view
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= `RCP_CFG_RESET;
    end else if (ce && cfg_wr_en) begin
      cfg_q <= {cfg_wr_data[`RCP_CFG_WIDTH-1:1], 1'b0};
    end
  end

  // two-stage lock synchroniser, raw lock comes from the analog loop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_meta_q <= 1'b0;
      lock_sync_q <= 1'b0;
    end else if (ce) begin
      lock_meta_q <= pll_lock_raw;
      lock_sync_q <= lock_meta_q;
    end
  end

  always_comb begin
    ctrl_d            = '0;
    ctrl_d.mode       = cfg_q[`RCP_BIT_CMOS] ? RCP_IN_CMOS : (cfg_q[`RCP_BIT_XTAL] ? RCP_IN_XTAL : RCP_IN_DIFF);
    ctrl_d.single_pin = cfg_q[`RCP_BIT_CMOS];
    ctrl_d.pll_pwr_dn = cfg_q[`RCP_BIT_PLL_PD];
    ctrl_d.pll_rst_n  = cfg_q[`RCP_BIT_PLL_RST_N];
    ctrl_d.lo_range   = cfg_q[`RCP_BIT_LO_RANGE] & ~cfg_q[`RCP_BIT_PLL_PD];
    ctrl_d.ref_div2   = cfg_q[`RCP_BIT_REF_DIV2];
    ctrl_d.vco_sel    = cfg_q[`RCP_BIT_VCO_SEL];
    ctrl_d.fb_div2    = cfg_q[`RCP_BIT_FB_DIV2];
    ctrl_d.fb_n       = cfg_q[`RCP_FB_N_HI:`RCP_FB_N_LO];
    ctrl_d.out_div2   = cfg_q[`RCP_BIT_OUT_DIV2];
    // select is a level only; the glitch-free mux itself lives in the clock tree
    ctrl_d.sel_pll    = ~cfg_q[`RCP_BIT_PLL_PD] & lock_sync_q;
    ctrl_d.mult_x4    = rcp_mult_x4(cfg_q);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else if (ce) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cfg_rd_data_q <= `RCP_CFG_RESET;
    end else if (ce) begin
      cfg_rd_data_q <= {cfg_q[`RCP_CFG_WIDTH-1:1], lock_sync_q};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_lock_held;
    (ce && pll_lock_raw) [*3];
  endsequence

  sequence s_write_then_ce;
    (ce && cfg_wr_en) ##1 ce;
  endsequence

  AST_RESET_DEFAULT: assert property (disable iff (1'b0) sys_rst ##1 !sys_rst |-> cfg_q == `RCP_CFG_RESET)
    else $error("config word not at default after reset");
  AST_CMOS_ONE_PIN: assert property (s_write_then_ce ##0 cfg_q[`RCP_BIT_CMOS]
                                     |=> ctrl_q.mode == RCP_IN_CMOS && ctrl_q.single_pin)
    else $error("cmos mode not applied");
  AST_PLL_RESET: assert property (ce && !cfg_q[`RCP_BIT_PLL_RST_N] |=> !ctrl_q.pll_rst_n)
    else $error("pll logic not held in reset");
  AST_PLL_POWER: assert property (s_write_then_ce |=> ctrl_q.pll_pwr_dn == $past(cfg_wr_data[`RCP_BIT_PLL_PD], 2))
    else $error("pll power control does not follow written bit");
  AST_LOCK_VIEW: assert property (s_lock_held |=> cfg_rd_data_q[`RCP_BIT_LOCK])
    else $error("lock not visible after synchroniser delay");
  AST_LOCK_SYNC: assert property (ce && !lock_meta_q ##1 ce |=> !cfg_rd_data_q[`RCP_BIT_LOCK])
    else $error("lock view bypassed the synchroniser");
  AST_SWITCH_PLL: assert property (ce && lock_sync_q && !cfg_q[`RCP_BIT_PLL_PD] |=> ctrl_q.sel_pll)
    else $error("sample clock not switched to pll on lock");
  AST_FALLBACK: assert property (ce && !lock_sync_q |=> !ctrl_q.sel_pll)
    else $error("sample clock not on reference while unlocked");
  AST_MULT_RANGE: assert property (ce |=> ctrl_q.mult_x4 >= `RCP_MULT_X4_MIN && ctrl_q.mult_x4 <= `RCP_MULT_X4_MAX)
    else $error("multiplication factor out of range");
  AST_N_ZERO: assert property (ce && cfg_q[15:9] == 7'h00 && !cfg_q[`RCP_BIT_REF_DIV2]
                               |=> ctrl_q.mult_x4 == 9'h080)
    else $error("n field zero not taken as 32");

  sequence s_lock_lost;
    (ce && !pll_lock_raw) [*3];
  endsequence

  property p_mode_decode;
    ce |=> ctrl_q.mode == ($past(cfg_q[`RCP_BIT_CMOS]) ? RCP_IN_CMOS
                           : ($past(cfg_q[`RCP_BIT_XTAL]) ? RCP_IN_XTAL : RCP_IN_DIFF));
  endproperty
  AST_MODE_DECODE: assert property (p_mode_decode)
    else $error("input mode does not follow config word");

  property p_mode_legal;
    ce |=> ctrl_q.mode != 2'b11;
  endproperty
  AST_MODE_LEGAL: assert property (p_mode_legal)
    else $error("unused input mode code driven");

  property p_single_pin;
    ce |=> ctrl_q.single_pin == $past(cfg_q[`RCP_BIT_CMOS]);
  endproperty
  AST_SINGLE_PIN: assert property (p_single_pin)
    else $error("single pin select does not follow cmos bit");

  property p_rst_follow;
    ce |=> ctrl_q.pll_rst_n == $past(cfg_q[`RCP_BIT_PLL_RST_N]);
  endproperty
  AST_RST_FOLLOW: assert property (p_rst_follow)
    else $error("pll logic reset does not follow bit 1");

  property p_pd_follow;
    ce |=> ctrl_q.pll_pwr_dn == $past(cfg_q[`RCP_BIT_PLL_PD]);
  endproperty
  AST_PD_FOLLOW: assert property (p_pd_follow)
    else $error("pll power-down does not follow bit 5");

  property p_lo_range;
    ce |=> ctrl_q.lo_range == ($past(cfg_q[`RCP_BIT_LO_RANGE]) && !$past(cfg_q[`RCP_BIT_PLL_PD]));
  endproperty
  AST_LO_RANGE: assert property (p_lo_range)
    else $error("low range select wrong");

  property p_lo_range_off;
    ce && cfg_q[`RCP_BIT_PLL_PD] |=> !ctrl_q.lo_range;
  endproperty
  AST_LO_RANGE_OFF: assert property (p_lo_range_off)
    else $error("low range applied with pll powered down");

  property p_ref_div2;
    ce |=> ctrl_q.ref_div2 == $past(cfg_q[`RCP_BIT_REF_DIV2]);
  endproperty
  AST_REF_DIV2: assert property (p_ref_div2)
    else $error("reference divider select wrong");

  property p_vco_sel;
    ce |=> ctrl_q.vco_sel == $past(cfg_q[`RCP_BIT_VCO_SEL]);
  endproperty
  AST_VCO_SEL: assert property (p_vco_sel)
    else $error("vco select wrong");

  property p_out_div2;
    ce |=> ctrl_q.out_div2 == $past(cfg_q[`RCP_BIT_OUT_DIV2]);
  endproperty
  AST_OUT_DIV2: assert property (p_out_div2)
    else $error("output divider select wrong");

  property p_fb_div2;
    ce |=> ctrl_q.fb_div2 == $past(cfg_q[`RCP_BIT_FB_DIV2]);
  endproperty
  AST_FB_DIV2: assert property (p_fb_div2)
    else $error("feedback second stage select wrong");

  property p_fb_n;
    ce |=> ctrl_q.fb_n == $past(cfg_q[`RCP_FB_N_HI:`RCP_FB_N_LO]);
  endproperty
  AST_FB_N: assert property (p_fb_n)
    else $error("feedback divide-by-n field wrong");

  property p_mult_top;
    ce && cfg_q[15:14] == 2'b01 && cfg_q[13:9] == 5'h00 && !cfg_q[`RCP_BIT_REF_DIV2] |=> ctrl_q.mult_x4 == `RCP_MULT_X4_MAX;
  endproperty
  AST_MULT_TOP: assert property (p_mult_top)
    else $error("top factor not 64");

  property p_mult_bottom;
    ce && cfg_q[15:14] == 2'b10 && cfg_q[13:9] == 5'h01 && cfg_q[`RCP_BIT_REF_DIV2] |=> ctrl_q.mult_x4 == `RCP_MULT_X4_MIN;
  endproperty
  AST_MULT_BOTTOM: assert property (p_mult_bottom)
    else $error("bottom factor not one quarter");

  property p_mult_fb_max;
    ce && cfg_q[15:14] == 2'b01 && cfg_q[13:9] == 5'h1f && !cfg_q[`RCP_BIT_REF_DIV2] |=> ctrl_q.mult_x4 == 9'h0f8;
  endproperty
  AST_MULT_FB_MAX: assert property (p_mult_fb_max)
    else $error("doubled feedback factor wrong");

  property p_mult_plain;
    ce && cfg_q[15:14] == 2'b00 && cfg_q[13:9] != 5'h00 && !cfg_q[`RCP_BIT_REF_DIV2] |=> ctrl_q.mult_x4 == {2'b00, $past(cfg_q[13:9]), 2'b00};
  endproperty
  AST_MULT_PLAIN: assert property (p_mult_plain)
    else $error("plain factor not equal to n");

  property p_rd_cfg;
    ce |=> cfg_rd_data_q[`RCP_CFG_WIDTH-1:1] == $past(cfg_q[`RCP_CFG_WIDTH-1:1]);
  endproperty
  AST_RD_CFG: assert property (p_rd_cfg)
    else $error("read view does not show stored word");

  property p_rd_lock;
    ce |=> cfg_rd_data_q[`RCP_BIT_LOCK] == $past(lock_sync_q);
  endproperty
  AST_RD_LOCK: assert property (p_rd_lock)
    else $error("read lock bit not from synchroniser");

  property p_write_lands;
    ce && cfg_wr_en |=> cfg_q[`RCP_CFG_WIDTH-1:1] == $past(cfg_wr_data[`RCP_CFG_WIDTH-1:1]);
  endproperty
  AST_WRITE_LANDS: assert property (p_write_lands)
    else $error("written word not stored");

  property p_bit0_clear;
    ce && cfg_wr_en |=> !cfg_q[`RCP_BIT_LOCK];
  endproperty
  AST_BIT0_CLEAR: assert property (p_bit0_clear)
    else $error("read-only bit stored by write");

  property p_no_write_hold;
    !(ce && cfg_wr_en) |=> $stable(cfg_q);
  endproperty
  AST_NO_WRITE_HOLD: assert property (p_no_write_hold)
    else $error("config word changed without write");

  property p_freeze_ctrl;
    !ce |=> $stable(ctrl_q);
  endproperty
  AST_FREEZE_CTRL: assert property (p_freeze_ctrl)
    else $error("control outputs moved with enable low");

  property p_freeze_rd;
    !ce |=> $stable(cfg_rd_data_q);
  endproperty
  AST_FREEZE_RD: assert property (p_freeze_rd)
    else $error("read view moved with enable low");

  property p_meta;
    ce |=> lock_meta_q == $past(pll_lock_raw);
  endproperty
  AST_META: assert property (p_meta)
    else $error("first synchroniser stage wrong");

  property p_sync;
    ce |=> lock_sync_q == $past(lock_meta_q);
  endproperty
  AST_SYNC: assert property (p_sync)
    else $error("second synchroniser stage wrong");

  property p_lock_lost;
    s_lock_lost |=> !cfg_rd_data_q[`RCP_BIT_LOCK] && !ctrl_q.sel_pll;
  endproperty
  AST_LOCK_LOST: assert property (p_lock_lost)
    else $error("no fallback after lock loss");

  property p_lock_gain;
    s_lock_held ##0 !cfg_q[`RCP_BIT_PLL_PD] |=> ctrl_q.sel_pll;
  endproperty
  AST_LOCK_GAIN: assert property (p_lock_gain)
    else $error("no switch to pll after lock");

  property p_pd_blocks;
    ce && cfg_q[`RCP_BIT_PLL_PD] |=> !ctrl_q.sel_pll;
  endproperty
  AST_PD_BLOCKS: assert property (p_pd_blocks)
    else $error("pll selected while powered down");

endmodule

// File: src/rcp_map.svh
// register layout, reset value and field positions of the clock configuration word
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH
`define RCP_CFG_WIDTH      16
`define RCP_CFG_RESET      16'h0020
`define RCP_BIT_OUT_DIV2   15
`define RCP_BIT_FB_DIV2    14
`define RCP_FB_N_HI        13
`define RCP_FB_N_LO        9
`define RCP_BIT_CMOS       7
`define RCP_BIT_XTAL       6
`define RCP_BIT_PLL_PD     5
`define RCP_BIT_LO_RANGE   4
`define RCP_BIT_REF_DIV2   3
`define RCP_BIT_VCO_SEL    2
`define RCP_BIT_PLL_RST_N  1
`define RCP_BIT_LOCK       0
`define RCP_N_ZERO_VALUE   6'h20
`define RCP_MULT_X4_MIN    9'h001
`define RCP_MULT_X4_MAX    9'h100
`endif

// File: src/rcp_pkg.sv
// types for the reference clock and pll control block
package rcp_pkg;
  typedef enum logic [1:0] {
    RCP_IN_DIFF = 2'b00,
    RCP_IN_XTAL = 2'b01,
    RCP_IN_CMOS = 2'b10
  } rcp_input_e;

  typedef struct packed {
    rcp_input_e mode;
    logic       single_pin;
    logic       pll_pwr_dn;
    logic       pll_rst_n;
    logic       lo_range;
    logic       ref_div2;
    logic       vco_sel;
    logic       fb_div2;
    logic [4:0] fb_n;
    logic       out_div2;
    logic       sel_pll;
    logic [8:0] mult_x4;
  } rcp_ctrl_s;
endpackage

// File: verification/rcp_pll_model.sv
// behavioural analog pll lock source facing the control block
`timescale 1ns/100ps
module rcp_pll_model (
  input  wire logic mclk,
  input  wire logic pwr_dn,
  input  wire logic rst_n,
  input  wire logic drop,
  output      logic lock
);
  logic [3:0] cnt_q = 4'h0;
  // a real loop needs settling time, so lock never comes at once
  always @(posedge mclk) begin
    if (pwr_dn || !rst_n || drop) cnt_q <= 4'h0;
    else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
  end
  assign lock = (cnt_q == 4'hf);
endmodule

// File: verification/rcp_ctrl_bench.sv
// self-checking bench for the pll control block
`timescale 1ns/100ps
module rcp_ctrl_bench;
  import rcp_pkg::*;
  logic        mclk = 1'b0, sys_rst = 1'b1, ce = 1'b1, wr_en = 1'b0, drop = 1'b0, lock;
  logic [15:0] wr_data = 16'h0000, rd;
  rcp_ctrl_s   ctrl;
  int          fails = 0, checks_done = 0, cyc = 0;
  logic [15:0] corner [10] = '{16'h0000, 16'h0020, 16'h0040, 16'h0060, 16'h0080, 16'h00a0,
                               16'h4000, 16'h8209, 16'h0016, 16'h0030};
  rcp_ctrl u_rcp_ctrl (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .cfg_wr_en(wr_en), .cfg_wr_data(wr_data),
    .pll_lock_raw(lock), .cfg_rd_data_q(rd), .ctrl_q(ctrl));
  rcp_pll_model u_rcp_pll_model (.mclk(mclk), .pwr_dn(ctrl.pll_pwr_dn), .rst_n(ctrl.pll_rst_n),
    .drop(drop), .lock(lock));
  initial begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      end_sim();
    end
  end
  function automatic rcp_ctrl_s exp_ctrl(logic [15:0] w);
    rcp_ctrl_s  e;
    logic [8:0] n;
    e = '0;
    e.mode = w[7] ? RCP_IN_CMOS : (w[6] ? RCP_IN_XTAL : RCP_IN_DIFF);
    {e.single_pin, e.pll_pwr_dn, e.pll_rst_n, e.ref_div2, e.vco_sel} = {w[7], w[5], w[1], w[3], w[2]};
    {e.out_div2, e.fb_div2, e.fb_n, e.lo_range} = {w[15:9], w[4] & ~w[5]};
    n = (w[13:9] == 5'h00) ? 9'h020 : {4'h0, w[13:9]};
    e.mult_x4 = ((n << 2) << w[14]) >> w[15] >> w[3];
    return e;
  endfunction
  task automatic chk(logic [24:0] got, logic [24:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [15:0] w);
    rcp_ctrl_s c;
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_data <= w;
    @(posedge mclk);
    wr_en <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    c = ctrl;
    c.sel_pll = 1'b0;
    if (ce) chk({10'h000, rd[15:1]}, {10'h000, w[15:1]});
    if (ce) chk(c, exp_ctrl(w));
  endtask
  task automatic wait_chk(int n, logic exp);
    repeat (n) @(posedge mclk);
    #1;
    chk({23'h000000, rd[0], ctrl.sel_pll}, {23'h000000, exp, exp});
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(42691));
    repeat (8) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({9'h000, rd}, 25'h0000020);
    chk(ctrl, 25'h0000000);
    foreach (corner[i]) wr(corner[i]);
    for (int i = 0; i < 30; i++) wr(16'($urandom));
    wr(16'h0802);
    wait_chk(30, 1'b1);
    @(posedge mclk);
    drop <= 1'b1;
    wait_chk(2, 1'b1);
    wait_chk(2, 1'b0);
    @(posedge mclk);
    drop <= 1'b0;
    wr(16'h0822);
    wait_chk(30, 1'b0);
    wr(16'h0800);
    wait_chk(30, 1'b0);
    @(posedge mclk);
    ce <= 1'b0;
    wr(16'hf0f2);
    ce <= 1'b1;
    #1;
    chk({10'h000, rd[15:1]}, 25'h0000400);
    end_sim();
  end
endmodule
